// >>> logic/tsp_regs.svh
// Constants for the two-wire sensor serial port: frame layout and timing counts
// Summary of operation
// [RULE1] Controller alone generates the serial clock
// [RULE2] Data line changes only after falling edges
// [RULE3] Controller starts every transfer, sensor never does
// [RULE4] Two bytes: direction plus address, then data
// [RULE5] Direction one means controller writes both bytes
// [RULE6] Write: controller shifts on fall, sensor samples rise
// [RULE7] Direction zero: sensor returns the data byte
// [RULE8] Controller releases data line after last address bit
// [RULE9] Sensor drives from falling edge after address
// [RULE10] Sensor releases on rising edge after last bit
// [RULE11] Sensor drives only during read data byte
// [RULE12] Resync: clock low, then high past timeout
// [RULE13] Watchdog timeout resets port, keeps register contents; here a timeout with wr_tgl_r high writes 00 to address 0
// [RULE14] Watchdog inactive while sensor is powered down
// [RULE15] Controller resyncs after power-up or ESD upsets
// [RULE16] Controller keeps data line driven between transfers
// [RULE17] Timeout 1.7 ms, 32 ms, 320 ms by mode
// [RULE18] Bits travel most significant first
// [RULE19] Sixteen bits per transfer, then expect new one
`ifndef TSP_REGS_SVH
`define TSP_REGS_SVH

`define TSP_ADDR_W              7
`define TSP_DATA_W              8
`define TSP_DIR_BIT             7
`define TSP_DIR_WRITE           1'b1
`define TSP_LAST_ADDR_BIT       4'h7
`define TSP_LAST_DATA_BIT       4'hF

`define TSP_CLK_MHZ             100
`define TSP_TMR_W               26

// Watchdog limits of the sensor, in microseconds, and in clk_sys cycles
`define TSP_WD_NORM_US          1700
`define TSP_WD_SLP1_US          32000
`define TSP_WD_SLP2_US          320000
`define TSP_WD_NORM_CYC         (`TSP_WD_NORM_US * `TSP_CLK_MHZ)
`define TSP_WD_SLP1_CYC         (`TSP_WD_SLP1_US * `TSP_CLK_MHZ)
`define TSP_WD_SLP2_CYC         (`TSP_WD_SLP2_US * `TSP_CLK_MHZ)

// Controller side timing
`define TSP_SCLK_HALF_CYC       5
`define TSP_RESYNC_LOW_TIME_US  1
`define TSP_RESYNC_LOW_CYC      (`TSP_RESYNC_LOW_TIME_US * `TSP_CLK_MHZ)
`define TSP_WD_WAIT_US          2040
`define TSP_WD_WAIT_CYC         (`TSP_WD_WAIT_US * `TSP_CLK_MHZ)

`endif

// >>> logic/tsp_pkg.sv
// Types shared by both ends of the two-wire sensor serial port
package tsp_pkg;

  typedef enum logic [1:0] {
    TSP_MODE_NORMAL,
    TSP_MODE_SLEEP1,
    TSP_MODE_SLEEP2
  } tsp_wd_mode_t;

  typedef enum logic [2:0] {
    TSP_CT_IDLE,
    TSP_CT_LOW,
    TSP_CT_HIGH,
    TSP_CT_RS_LOW,
    TSP_CT_RS_HIGH
  } tsp_ctl_state_t;

endpackage : tsp_pkg

// >>> logic/tsp_if.sv
// Two-wire link between the serial port controller and the sensor
`timescale 1ns/10ps
interface tsp_if;
  logic sclk;
  logic ctl_out;
  logic ctl_oe_n;
  logic dev_out;
  logic dev_oe_n;
  logic sdio;

  // Released line is pulled high
  assign sdio = !ctl_oe_n ? ctl_out : (!dev_oe_n ? dev_out : 1'b1);

  modport ctrl (
    output sclk,
    output ctl_out,
    output ctl_oe_n,
    input  sdio
  );

  modport sensor (
    input  sclk,
    input  sdio,
    output dev_out,
    output dev_oe_n
  );
endinterface : tsp_if

// >>> logic/tsp_sensor.sv
// Sensor end of the two-wire serial port with watchdog resynchronisation
`timescale 1ns/10ps
`include "tsp_regs.svh"
module tsp_sensor #(
  parameter int unsigned WD_NORM_CYC = `TSP_WD_NORM_CYC,
  parameter int unsigned WD_SLP1_CYC = `TSP_WD_SLP1_CYC,
  parameter int unsigned WD_SLP2_CYC = `TSP_WD_SLP2_CYC
) (
  tsp_if.sensor                      link,
  input  wire logic                  clk_sys,
  input  wire logic                  nrst,
  input  wire logic                  power_down_input,
  input  wire tsp_pkg::tsp_wd_mode_t sleep_mode,
  output logic                       wr_valid,
  output logic [`TSP_ADDR_W-1:0]     wr_addr,
  output logic [`TSP_DATA_W-1:0]     wr_data,
  output logic [`TSP_ADDR_W-1:0]     rd_addr,
  input  wire logic [`TSP_DATA_W-1:0] rd_data,
  output logic                       port_resync
);
  import tsp_pkg::*;

  localparam int TW = `TSP_TMR_W;

  // Link domain state
  logic [3:0]              bit_cnt_r;
  logic [6:0]              sh_r;
  logic                    dir_r;
  logic [`TSP_ADDR_W-1:0]  addr_r;
  logic [`TSP_ADDR_W-1:0]  wr_addr_hold_r;
  logic [`TSP_DATA_W-1:0]  wr_data_hold_r;
  logic                    wr_tgl_r;
  logic                    drive_pos_r;
  logic                    drive_neg_r;
  logic [`TSP_DATA_W-1:0]  tx_r;

  // System domain state
  logic                    sclk_s1_r;
  logic                    sclk_s2_r;
  logic [TW-1:0]           wd_cnt_r;
  logic                    wd_armed_r;
  logic                    wd_pulse_r;
  logic                    tgl_s1_r;
  logic                    tgl_s2_r;
  logic                    tgl_s3_r;
  logic                    wr_valid_r;
  logic [`TSP_ADDR_W-1:0]  wr_addr_r;
  logic [`TSP_DATA_W-1:0]  wr_data_r;
  logic [TW-1:0]           wd_limit;
  logic                    port_rst_n;

  // The watchdog pulse clears only the link logic; if wr_tgl_r was high, its reset crosses as a write of 00 to address 0
  assign port_rst_n = nrst & ~wd_pulse_r; // [RULE13]

  // Bit counter wraps after sixteen rising edges to wait for a new direction bit
  always_ff @(posedge link.sclk or negedge port_rst_n)
  begin
    if (!port_rst_n)
      bit_cnt_r <= 4'h0;
    else
      bit_cnt_r <= bit_cnt_r + 4'h1; // [RULE19] [RULE3]
  end

  // Input shifter, sampled on rising edges, first bit is the direction
  always_ff @(posedge link.sclk or negedge port_rst_n)
  begin
    if (!port_rst_n)
      sh_r <= 7'h00;
    else
      sh_r <= {sh_r[5:0], link.sdio}; // [RULE6] [RULE18]
  end

  // Address byte decode at the eighth rising edge
  always_ff @(posedge link.sclk or negedge port_rst_n)
  begin
    if (!port_rst_n)
    begin
      dir_r  <= 1'b0;
      addr_r <= '0;
    end
    else if (bit_cnt_r == `TSP_LAST_ADDR_BIT)
    begin
      dir_r  <= sh_r[6]; // [RULE4]
      addr_r <= {sh_r[5:0], link.sdio}; // [RULE4]
    end
  end

  // Completed write is held for the crossing until the next write transfer ends or the port resets
  always_ff @(posedge link.sclk or negedge port_rst_n)
  begin
    if (!port_rst_n)
    begin
      wr_addr_hold_r <= '0;
      wr_data_hold_r <= '0;
      wr_tgl_r       <= 1'b0;
    end
    else if (bit_cnt_r == `TSP_LAST_DATA_BIT && dir_r == `TSP_DIR_WRITE)
    begin
      wr_addr_hold_r <= addr_r; // [RULE5]
      wr_data_hold_r <= {sh_r, link.sdio}; // [RULE5] [RULE18]
      wr_tgl_r       <= ~wr_tgl_r;
    end
  end

  // Read window: opens after the last address bit, closes at the rising
  // edge after the last data bit
  always_ff @(posedge link.sclk or negedge port_rst_n)
  begin
    if (!port_rst_n)
      drive_pos_r <= 1'b0;
    else if (bit_cnt_r == `TSP_LAST_ADDR_BIT)
      drive_pos_r <= ~sh_r[6]; // [RULE7]
    else if (bit_cnt_r == `TSP_LAST_DATA_BIT)
      drive_pos_r <= 1'b0; // [RULE10]
  end

  // Transmit side moves only on falling edges
  always_ff @(negedge link.sclk or negedge port_rst_n)
  begin
    if (!port_rst_n)
    begin
      drive_neg_r <= 1'b0;
      tx_r        <= '0;
    end
    else
    begin
      drive_neg_r <= drive_pos_r; // [RULE9]
      if (drive_pos_r && !drive_neg_r)
        tx_r <= rd_data; // [RULE2] [RULE7]
      else
        tx_r <= {tx_r[6:0], 1'b0}; // [RULE2] [RULE18]
    end
  end

  // Both edges must agree before driving, so the release is immediate at
  // the closing rising edge and the start waits for the falling edge
  assign link.dev_oe_n = ~(drive_pos_r & drive_neg_r); // [RULE11] [RULE9] [RULE10]
  assign link.dev_out  = tx_r[7];
  assign rd_addr       = addr_r;

  // Clock level into the system domain
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sclk_s1_r <= 1'b1;
      sclk_s2_r <= 1'b1;
    end
    else
    begin
      sclk_s1_r <= link.sclk;
      sclk_s2_r <= sclk_s1_r;
    end
  end

  always_comb
  begin
    case (sleep_mode)
      TSP_MODE_NORMAL: wd_limit = TW'(WD_NORM_CYC); // [RULE17]
      TSP_MODE_SLEEP1: wd_limit = TW'(WD_SLP1_CYC); // [RULE17]
      TSP_MODE_SLEEP2: wd_limit = TW'(WD_SLP2_CYC); // [RULE17]
      default:         wd_limit = TW'(WD_NORM_CYC);
    endcase
  end

  // One pulse per high period; the pulse ends while the clock still stands
  // high, so the link logic leaves reset before any further edge
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      wd_cnt_r   <= '0;
      wd_armed_r <= 1'b1;
      wd_pulse_r <= 1'b0;
    end
    else if (power_down_input || !sclk_s2_r)
    begin
      wd_cnt_r   <= '0; // [RULE14]
      wd_armed_r <= 1'b1;
      wd_pulse_r <= 1'b0;
    end
    else if (wd_armed_r && wd_cnt_r >= wd_limit - TW'(1))
    begin
      wd_armed_r <= 1'b0;
      wd_pulse_r <= 1'b1; // [RULE13] [RULE17]
    end
    else
    begin
      wd_pulse_r <= 1'b0;
      if (wd_armed_r)
        wd_cnt_r <= wd_cnt_r + TW'(1);
    end
  end

  // Write event crosses by toggle; held words are stable long before use
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      tgl_s1_r   <= 1'b0;
      tgl_s2_r   <= 1'b0;
      tgl_s3_r   <= 1'b0;
      wr_valid_r <= 1'b0;
      wr_addr_r  <= '0;
      wr_data_r  <= '0;
    end
    else
    begin
      tgl_s1_r   <= wr_tgl_r;
      tgl_s2_r   <= tgl_s1_r;
      tgl_s3_r   <= tgl_s2_r;
      wr_valid_r <= tgl_s2_r ^ tgl_s3_r;
      if (tgl_s2_r ^ tgl_s3_r)
      begin
        wr_addr_r <= wr_addr_hold_r;
        wr_data_r <= wr_data_hold_r;
      end
    end
  end

  assign wr_valid    = wr_valid_r;
  assign wr_addr     = wr_addr_r;
  assign wr_data     = wr_data_r;
  assign port_resync = wd_pulse_r;

endmodule : tsp_sensor

// >>> logic/tsp_ctrl.sv
// Controller end of the two-wire serial port: makes the clock, runs transfers
`timescale 1ns/10ps
`include "tsp_regs.svh"
module tsp_ctrl #(
  parameter int unsigned HALF_CYC       = `TSP_SCLK_HALF_CYC,
  parameter int unsigned RESYNC_LOW_CYC = `TSP_RESYNC_LOW_CYC,
  parameter int unsigned WD_WAIT_CYC    = `TSP_WD_WAIT_CYC
) (
  tsp_if.ctrl                         link,
  input  wire logic                   clk_sys,
  input  wire logic                   nrst,
  input  wire logic                   req_valid,
  input  wire logic                   req_write,
  input  wire logic [`TSP_ADDR_W-1:0] req_addr,
  input  wire logic [`TSP_DATA_W-1:0] req_wdata,
  input  wire logic                   resync_req,
  output logic                        req_ready,
  output logic                        rsp_valid,
  output logic [`TSP_DATA_W-1:0]      rsp_rdata
);
  import tsp_pkg::*;

  localparam int TW = `TSP_TMR_W;

  tsp_ctl_state_t          state_r;
  tsp_ctl_state_t          state_nxt;
  logic [TW-1:0]           tmr_r;
  logic [3:0]              bit_r;
  logic [14:0]             sh_r;
  logic                    rd_r;
  logic [`TSP_DATA_W-1:0]  rx_r;
  logic                    sclk_r;
  logic                    out_r;
  logic                    oe_n_r;
  logic                    ready_r;
  logic                    rsp_valid_r;
  logic [`TSP_DATA_W-1:0]  rsp_rdata_r;
  logic                    sdio_s1_r;
  logic                    sdio_s2_r;
  logic                    phase_end;
  logic                    start;
  logic                    fall;
  logic                    rise;
  logic                    done;

  assign phase_end = (tmr_r == '0);
  assign start     = (state_r == TSP_CT_IDLE) && req_valid && !resync_req; // [RULE3]
  assign rise      = (state_r == TSP_CT_LOW) && phase_end;
  assign done      = (state_r == TSP_CT_HIGH) && phase_end && bit_r == `TSP_LAST_DATA_BIT;
  assign fall      = start || ((state_r == TSP_CT_HIGH) && phase_end && !done);

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      TSP_CT_IDLE:
      begin
        if (resync_req)
          state_nxt = TSP_CT_RS_LOW;
        else if (req_valid)
          state_nxt = TSP_CT_LOW;
      end
      TSP_CT_LOW:     if (phase_end) state_nxt = TSP_CT_HIGH;
      TSP_CT_HIGH:    if (phase_end) state_nxt = done ? TSP_CT_IDLE : TSP_CT_LOW;
      TSP_CT_RS_LOW:  if (phase_end) state_nxt = TSP_CT_RS_HIGH;
      TSP_CT_RS_HIGH: if (phase_end) state_nxt = TSP_CT_IDLE;
      default:        state_nxt = TSP_CT_IDLE;
    endcase
  end

  // State, phase timer and bit count
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= TSP_CT_IDLE;
      tmr_r   <= '0;
      bit_r   <= 4'h0;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_r == TSP_CT_IDLE && resync_req)
        tmr_r <= TW'(RESYNC_LOW_CYC - 1); // [RULE12] [RULE15]
      else if (state_r == TSP_CT_RS_LOW && phase_end)
        tmr_r <= TW'(WD_WAIT_CYC - 1); // [RULE12]
      else if (fall || rise)
        tmr_r <= TW'(HALF_CYC - 1);
      else if (!phase_end)
        tmr_r <= tmr_r - TW'(1);
      if (start)
        bit_r <= 4'h0;
      else if (fall)
        bit_r <= bit_r + 4'h1;
    end
  end

  // Clock is made here from clk_sys and idles high
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      sclk_r <= 1'b1;
    else
      sclk_r <= !(state_nxt == TSP_CT_LOW || state_nxt == TSP_CT_RS_LOW); // [RULE1] [RULE12]
  end

  // Outgoing bits change together with the falling clock
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sh_r   <= '0;
      rd_r   <= 1'b0;
      out_r  <= 1'b0;
      oe_n_r <= 1'b0;
    end
    else
    begin
      if (start)
      begin
        out_r <= req_write; // [RULE4] [RULE5] [RULE7] [RULE18]
        sh_r  <= {req_addr, req_wdata};
        rd_r  <= ~req_write;
      end
      else if (fall && !(rd_r && bit_r >= `TSP_LAST_ADDR_BIT))
      begin
        out_r <= sh_r[14]; // [RULE2] [RULE6]
        sh_r  <= {sh_r[13:0], 1'b0};
      end
      // Release one cycle into the high phase: letting go on the rising edge
      // itself would race the sensor's sample of the last address bit
      if (state_r == TSP_CT_HIGH && rd_r && bit_r == `TSP_LAST_ADDR_BIT)
        oe_n_r <= 1'b1; // [RULE8]
      else if (done)
        oe_n_r <= 1'b0; // [RULE10] [RULE16]
    end
  end

  // Data pin passes two flip-flops before sampling
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sdio_s1_r <= 1'b1;
      sdio_s2_r <= 1'b1;
    end
    else
    begin
      sdio_s1_r <= link.sdio;
      sdio_s2_r <= sdio_s1_r;
    end
  end

  // Read bits are taken just before each rising edge of the data byte
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_r        <= '0;
      rsp_valid_r <= 1'b0;
      rsp_rdata_r <= '0;
      ready_r     <= 1'b0;
    end
    else
    begin
      if (rise && bit_r > `TSP_LAST_ADDR_BIT)
        rx_r <= {rx_r[6:0], sdio_s2_r}; // [RULE7] [RULE18]
      rsp_valid_r <= done;
      if (done)
        rsp_rdata_r <= rd_r ? rx_r : '0;
      ready_r <= (state_nxt == TSP_CT_IDLE) && !(state_r == TSP_CT_IDLE && (req_valid || resync_req));
    end
  end

  assign link.sclk     = sclk_r;
  assign link.ctl_out  = out_r;
  assign link.ctl_oe_n = oe_n_r;
  assign req_ready     = ready_r;
  assign rsp_valid     = rsp_valid_r;
  assign rsp_rdata     = rsp_rdata_r;

endmodule : tsp_ctrl

// >>> testbench/tsp_chk.sv
// Concurrent checks on the two-wire link between the controller and the sensor
`timescale 1ns/10ps
module tsp_chk #(
  parameter int unsigned HALF_CYC = 5
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic ctl_out,
  input wire logic ctl_oe_n,
  input wire logic dev_out,
  input wire logic dev_oe_n,
  input wire logic sdio
);
  logic       sclk_q_r;
  logic [7:0] hi_r;
  logic [4:0] cnt_r;
  logic       dir_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sclk_q_r <= 1'b1;
      hi_r     <= 8'h00;
    end
    else
    begin
      sclk_q_r <= sclk;
      hi_r     <= !sclk ? 8'h00 : (hi_r == 8'hFF ? hi_r : hi_r + 8'h01);
    end
  end

  // Rises seen in the current frame; a long high stretch means the link is idle
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_r <= 5'h00;
      dir_r <= 1'b0;
    end
    else if (sclk && !sclk_q_r)
    begin
      cnt_r <= (cnt_r == 5'h10 || cnt_r == 5'h00) ? 5'h01 : cnt_r + 5'h01;
      if (cnt_r == 5'h10 || cnt_r == 5'h00)
        dir_r <= sdio;
    end
    else if (hi_r >= 8'(4 * HALF_CYC))
      cnt_r <= 5'h00;
  end

  a_no_drive_clash: assert property (ctl_oe_n || dev_oe_n)
    else $error("both ends drive the data line");
  a_ctl_moves_fall: assert property (!ctl_oe_n && $changed(ctl_out) |-> $fell(sclk))
    else $error("controller data changed off a falling clock");
  a_dev_moves_fall: assert property (!dev_oe_n && $changed(dev_out) |-> $fell(sclk))
    else $error("sensor data changed off a falling clock");
  a_dev_start_late: assert property ($fell(dev_oe_n) |-> $fell(sclk) && cnt_r == 5'h08 && !dir_r)
    else $error("sensor began driving at the wrong moment");
  a_dev_stop_rise: assert property ($rose(dev_oe_n) |-> $rose(sclk) && cnt_r == 5'h0F)
    else $error("sensor did not release at the last rise");
  a_ctl_free_read: assert property ($rose(ctl_oe_n) |-> sclk && !dir_r && (cnt_r + 5'($rose(sclk))) == 5'h08)
    else $error("controller released outside the read turnaround");
  a_ctl_back_soon: assert property ($rose(dev_oe_n) |-> ##[1:40] !ctl_oe_n)
    else $error("controller did not take the line back");
  a_wr_dev_quiet: assert property (!dev_oe_n |-> !dir_r)
    else $error("sensor drove during a write");
  a_early_dev_quiet: assert property (!dev_oe_n |-> cnt_r >= 5'h08)
    else $error("sensor drove before the address was complete");

  cover property ($fell(dev_oe_n));
  cover property ($rose(sclk) && cnt_r == 5'h0F && dir_r);
  cover property (hi_r == 8'hFF);
endmodule : tsp_chk

// >>> testbench/tsp_tb_top.sv
// Self-checking bench: controller and sensor joined over the two-wire link
`timescale 1ns/10ps
`include "tsp_regs.svh"
module tsp_tb_top;
  import tsp_pkg::*;
  typedef struct packed {logic w; logic [6:0] a; logic [7:0] d; logic [7:0] e;} tsp_row_t;
  logic                   clk_sys = 1'b0;
  logic                   nrst = 1'b0;
  logic                   req_valid = 1'b0;
  logic                   req_write = 1'b0;
  logic [`TSP_ADDR_W-1:0] req_addr = '0;
  logic [`TSP_DATA_W-1:0] req_wdata = '0;
  logic                   resync_req = 1'b0;
  logic                   power_down_input = 1'b0;
  tsp_wd_mode_t           sleep_mode = TSP_MODE_NORMAL;
  logic                   req_ready, rsp_valid, wr_valid, port_resync;
  logic [`TSP_DATA_W-1:0] rsp_rdata, wr_data, rd_data;
  logic [`TSP_ADDR_W-1:0] wr_addr, rd_addr;
  logic [7:0]             regs [128];
  logic [15:0]            frame_r = '0;
  int                     n_fail = 0;
  int                     n_compared = 0;
  int                     cyc = 0;
  // Writes at both address ends, then read-backs and one untouched register
  tsp_row_t               rows [9] = '{24'h80A500, 24'hFF5A00, 24'hAAFF00, 24'hD50000,
    24'h0000A5, 24'h7F005A, 24'h2A00FF, 24'h550000, 24'h01003D};

  tsp_if link ();
  tsp_ctrl #(.RESYNC_LOW_CYC(10), .WD_WAIT_CYC(900)) u_tsp_ctrl (
    .link(link), .clk_sys(clk_sys), .nrst(nrst), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .resync_req(resync_req), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata));
  // Watchdog limits shortened; the controller wait outlasts the longest one
  tsp_sensor #(.WD_NORM_CYC(200), .WD_SLP1_CYC(400), .WD_SLP2_CYC(800)) u_tsp_sensor (
    .link(link), .clk_sys(clk_sys), .nrst(nrst), .power_down_input(power_down_input),
    .sleep_mode(sleep_mode), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_addr(rd_addr), .rd_data(rd_data), .port_resync(port_resync));
  tsp_chk u_tsp_chk (
    .clk_sys(clk_sys), .nrst(nrst), .sclk(link.sclk), .ctl_out(link.ctl_out),
    .ctl_oe_n(link.ctl_oe_n), .dev_out(link.dev_out), .dev_oe_n(link.dev_oe_n),
    .sdio(link.sdio));

  always #5 clk_sys = ~clk_sys;
  assign rd_data = regs[rd_addr];
  always @(posedge clk_sys) if (wr_valid === 1'b1) regs[wr_addr] <= wr_data;
  // Wire-level view of each frame, independent of either end
  always @(posedge link.sclk) frame_r <= {frame_r[14:0], link.sdio};

  task automatic close_out();
    if (n_fail == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      close_out();
    end
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d,
                      input logic [7:0] e);
    int t;
    t = 0;
    while (req_ready !== 1'b1 && t < 200) begin @(negedge clk_sys); t++; end
    chk("idle_lines", {link.sclk, link.ctl_oe_n, link.dev_oe_n}, 3'h5);
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    @(negedge clk_sys);
    req_valid = 1'b0;
    t = 0;
    while (rsp_valid !== 1'b1 && t < 400) begin @(negedge clk_sys); t++; end
    chk("rsp_rdata", rsp_rdata, e);
    chk("wire_frame", frame_r, {w, a, w ? d : e});
    if (w) chk("wr_port", {wr_addr, wr_data}, {a, d});
  endtask : xfer

  task automatic resync(input int lim, input logic fire);
    int t, n, k;
    t = 0;
    n = 0;
    k = 0;
    while (req_ready !== 1'b1 && k < 200) begin @(negedge clk_sys); k++; end
    resync_req = 1'b1;
    @(negedge clk_sys);
    resync_req = 1'b0;
    k = 0;
    while (link.sclk !== 1'b0 && k < 20) begin @(negedge clk_sys); k++; end
    k = 0;
    while (req_ready !== 1'b1 && k < 3000)
    begin
      @(negedge clk_sys);
      k++;
      t = link.sclk ? t + 1 : 0;
      if (port_resync === 1'b1)
      begin
        n++;
        chk("wd_delay", 16'(t >= lim && t <= lim + 8), 16'h0001);
      end
    end
    chk("wd_fires", 16'(n), 16'(fire));
  endtask : resync

  initial
  begin
    for (int i = 0; i < 128; i++) regs[i] = 8'(i) ^ 8'h3C;
    repeat (6) @(negedge clk_sys);
    nrst = 1'b1;
    foreach (rows[i]) xfer(rows[i].w, rows[i].a, rows[i].d, rows[i].e);
    sleep_mode = TSP_MODE_NORMAL;
    resync(200, 1'b1);
    sleep_mode = TSP_MODE_SLEEP1;
    resync(400, 1'b1);
    sleep_mode = TSP_MODE_SLEEP2;
    resync(800, 1'b1);
    sleep_mode = TSP_MODE_NORMAL;
    power_down_input = 1'b1;
    resync(200, 1'b0);
    power_down_input = 1'b0;
    // Contents survive the port resets
    xfer(1'b0, 7'h2A, 8'h00, 8'hFF);
    @(negedge clk_sys);
    nrst = 1'b0;
    @(negedge clk_sys);
    chk("reset_outs", {link.sclk, link.dev_oe_n, link.ctl_oe_n, req_ready, rsp_valid,
        wr_valid, port_resync}, 7'h60);
    @(negedge clk_sys);
    nrst = 1'b1;
    xfer(1'b1, 7'h11, 8'h81, 8'h00);
    xfer(1'b0, 7'h11, 8'h00, 8'h81);
    close_out();
  end
endmodule : tsp_tb_top
